// ===== tb/rpc_capture_port_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); \
		end \
	end
module rpc_capture_port_tb
	import rpc_pkg::*;
	;

	logic pclk;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pix_valid;
	logic capture_busy;
	logic irq;
	rpc_pixel_type pix_out;
	rpc_pixel_type want;
	rpc_pixel_type last_px;
	logic pck;
	logic gate;
	logic [19:0] bus;
	logic [19:0] mask = 20'hFFFFF;
	logic [31:0] rd;
	logic err;
	logic [7:0] ofs[6] = '{CTRL_OFS, LIMIT_OFS, STATUS_OFS, MASK_OFS, COUNT_OFS, DATA_OFS};
	int w_bits[4] = '{8, 10, 16, 20};
	int lim;
	int n_mismatch = 0;
	int tests_run = 0;

	rpc_capture_port uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_clock_line_zero(pck),
		.port_control_line_zero(gate), .port_pixel_bus(bus), .pix_out(pix_out),
		.pix_valid(pix_valid), .capture_busy(capture_busy), .irq(irq));

	rpc_sensor_model sensor (.pix_clk(pck), .row_active(gate), .frame_window(),
		.pix_data(bus));

	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus access and verdict
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rchk

	task conclude;
		if (n_mismatch == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	// every captured word against what the sensor sent
	always @(posedge pclk)
		if (pix_valid === 1'b1)
		begin
			if (sensor.sent.size() == 0)
				`CHK(1'b1, 1'b0)
			else
			begin
				want = sensor.sent.pop_front();
				last_px = want;
				`CHK(pix_out, {want.data & mask, want.colour})
			end
		end

	initial
	begin
		#100000;
		n_mismatch++;
		conclude();
	end

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rchk(ofs[i], 32'h0);
		`CHK(irq, 1'b0)
		apb(1'b0, 8'h40, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		apb(1'b1, LIMIT_OFS, 32'hFFFFFFFF);
		rchk(LIMIT_OFS, 32'h0FFF0FFF);
		apb(1'b1, COUNT_OFS, 32'hFFFFFFFF);
		rchk(COUNT_OFS, 32'h0);
		for (int w = 0; w < 4; w++)
		begin
			mask = 20'((32'h1 << w_bits[w]) - 1);
			lim = (w == 1) ? 5 : 6;
			apb(1'b1, CTRL_OFS, 32'h0);
			apb(1'b1, MASK_OFS, {31'h0, w != 0});
			apb(1'b1, LIMIT_OFS, 32'(lim));
			apb(1'b1, CTRL_OFS, {29'h0, 2'(w), 1'b1});
			rchk(COUNT_OFS, 32'h80000000);
			sensor.sent.delete();
			sensor.frame(2, 3, 10'h2A5, 10'(w * 64));
			repeat (10) @(posedge pclk);
			`CHK(irq, 1'(w != 0))
			`CHK(capture_busy, 1'b0)
			`CHK(sensor.sent.size(), 6 - lim)
			rchk(COUNT_OFS, 32'(lim));
			rchk(DATA_OFS, {6'h0, last_px.colour, 4'h0, last_px.data & mask});
			rchk(STATUS_OFS, 32'((w == 1) ? 3 : 1));
			rchk(STATUS_OFS, 32'h0);
			`CHK(irq, 1'b0)
		end
		conclude();
	end

endmodule : rpc_capture_port_tb

// ===== tb/rpc_sensor_model.sv
`timescale 1ns/1ps
module rpc_sensor_model
	import rpc_pkg::*;
	(
	output logic pix_clk,
	output logic row_active,
	output logic frame_window,
	output logic [19:0] pix_data
	);

	rpc_pixel_type sent[$];

	initial
	begin
		pix_clk = 1'b0;
		row_active = 1'b0;
		frame_window = 1'b0;
		pix_data = 20'h5A5A5;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one pixel clock period, outputs change with the rising edge
	task automatic tick(input logic gate, input logic [19:0] word);
		pix_clk <= 1'b1;
		row_active <= gate;
		pix_data <= word;
		#62.5;
		pix_clk <= 1'b0;
		#62.5;
	endtask : tick

	////////////////////////////////////////////////////////////////////////////////
	// rows of bayer pixels, then blanking rows; clock stops after the frame
	task automatic frame(input int rows, input int cols, input logic [9:0] hi,
		input logic [9:0] base);
		rpc_pixel_type px;
		frame_window = 1'b1;
		for (int r = 0; r < rows; r++)
		begin
			tick(1'b0, ~pix_data);
			tick(1'b0, ~pix_data);
			for (int c = 0; c < cols; c++)
			begin
				px.data = {hi, 10'(base + r * 16 + c)};
				if (r % 2 == 0)
					px.colour = (c % 2 == 1) ? COLOUR_RED : COLOUR_GREEN;
				else
					px.colour = (c % 2 == 1) ? COLOUR_GREEN : COLOUR_BLUE;
				sent.push_back(px);
				tick(1'b1, px.data);
			end
		end
		frame_window = 1'b0;
		for (int b = 0; b < 3 * cols; b++)
			tick(1'b0, ~pix_data);
		pix_data <= ~pix_data;
	endtask : frame

endmodule : rpc_sensor_model

// ===== verilog/rpc_capture_port.sv
`timescale 1ns/1ps
module rpc_capture_port
	import rpc_pkg::*;
	(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic port_clock_line_zero,
	input wire logic port_control_line_zero,
	input wire logic [19:0] port_pixel_bus,
	output rpc_pixel_type pix_out,
	output logic pix_valid,
	output logic capture_busy,
	output logic irq
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [PORT_W+1:0] sync_bus;
	logic clk_s;
	logic sample_gate;
	logic [19:0] data_s;
	logic clk_prev;
	logic pixel_edge;

	rpc_sync #(.WIDTH(PORT_W + 2)) u_sync
	(
		.clk(pclk),
		.rst_n(presetn),
		.din({port_clock_line_zero, port_control_line_zero, port_pixel_bus}),
		.dout(sync_bus)
	);

	assign clk_s = sync_bus[PORT_W+1];
	assign sample_gate = sync_bus[PORT_W];
	assign data_s = sync_bus[PORT_W-1:0];

	// sample on the falling edge, mid-cycle, since the sensor moves data on the rising one
	assign pixel_edge = clk_prev & ~clk_s;

	////////////////////////////////////////////////////////////////////////////////
	// register file
	logic ctrl_en;
	rpc_width_type ctrl_width;
	logic [11:0] count_low_limit;
	logic [11:0] count_high_limit;
	logic [STAT_W-1:0] status;
	logic [STAT_W-1:0] irq_mask;
	logic [31:0] prdata_q;
	logic next_ctrl_en;
	rpc_width_type next_ctrl_width;
	logic [11:0] next_count_low_limit;
	logic [11:0] next_count_high_limit;
	logic [STAT_W-1:0] next_status;
	logic [STAT_W-1:0] next_irq_mask;
	logic [31:0] next_prdata_q;
	logic [STAT_W-1:0] stat_set;
	logic [COUNT_W-1:0] limit_full;
	logic [COUNT_W-1:0] count;
	rpc_state_type state;
	logic addr_ok;
	logic wr_acc;
	logic rd_acc;

	assign limit_full = {count_high_limit, count_low_limit};
	assign addr_ok = (paddr == CTRL_OFS) || (paddr == LIMIT_OFS) || (paddr == STATUS_OFS)
		|| (paddr == MASK_OFS) || (paddr == COUNT_OFS) || (paddr == DATA_OFS);
	assign wr_acc = psel & penable & pwrite & addr_ok;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata = prdata_q;
	assign irq = |(status & irq_mask);
	assign capture_busy = (state == ST_CAPTURE) || (state == ST_HOLDOFF);

	always_comb
	begin
		next_ctrl_en = ctrl_en;
		next_ctrl_width = ctrl_width;
		next_count_low_limit = count_low_limit;
		next_count_high_limit = count_high_limit;
		next_irq_mask = irq_mask;
		next_prdata_q = prdata_q;
		next_status = status;
		if (wr_acc)
		begin
			unique case (paddr)
				CTRL_OFS:
				begin
					next_ctrl_en = pwdata[CTRL_EN_BIT];
					next_ctrl_width = rpc_width_type'(pwdata[CTRL_WIDTH_LSB +: 2]);
				end
				LIMIT_OFS:
				begin
					next_count_low_limit = pwdata[LIMIT_LOW_LSB +: LIMIT_FIELD_W];
					next_count_high_limit = pwdata[LIMIT_HIGH_LSB +: LIMIT_FIELD_W];
				end
				MASK_OFS: next_irq_mask = pwdata[STAT_W-1:0];
				default: ;
			endcase
		end
		// read data is latched in the setup cycle
		if (psel & ~penable & ~pwrite)
		begin
			next_prdata_q = 32'h00000000;
			unique case (paddr)
				CTRL_OFS: next_prdata_q = {29'h0, ctrl_width, ctrl_en};
				LIMIT_OFS: next_prdata_q = {4'h0, count_high_limit, 4'h0, count_low_limit};
				STATUS_OFS: next_prdata_q = {30'h0, status};
				MASK_OFS: next_prdata_q = {30'h0, irq_mask};
				COUNT_OFS: next_prdata_q = {capture_busy, 7'h0, count};
				DATA_OFS: next_prdata_q = {6'h0, pix_out.colour, 4'h0, pix_out.data};
				default: next_prdata_q = 32'h00000000;
			endcase
		end
		// read clears only the bits reported, a new event wins over the clear
		if (rd_acc && paddr == STATUS_OFS)
			next_status = status & ~prdata_q[STAT_W-1:0];
		next_status = next_status | stat_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_en <= CTRL_EN_RESET;
			ctrl_width <= WIDTH_8;
			count_low_limit <= LIMIT_RESET;
			count_high_limit <= LIMIT_RESET;
			irq_mask <= MASK_RESET;
			status <= '0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			ctrl_en <= next_ctrl_en;
			ctrl_width <= next_ctrl_width;
			count_low_limit <= next_count_low_limit;
			count_high_limit <= next_count_high_limit;
			irq_mask <= next_irq_mask;
			status <= next_status;
			prdata_q <= next_prdata_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// capture engine
	logic en_prev;
	logic row_odd;
	logic col_odd;
	logic gate_seen;
	logic [1:0] hold_cnt;
	rpc_state_type next_state;
	logic [COUNT_W-1:0] next_count;
	logic next_row_odd;
	logic next_col_odd;
	logic next_gate_seen;
	logic [1:0] next_hold_cnt;
	rpc_pixel_type next_pix_out;
	logic next_pix_valid;
	logic [COUNT_W-1:0] count_inc;

	assign count_inc = COUNT_W'(count + 24'h1);

	always_comb
	begin
		next_state = state;
		next_count = count;
		next_row_odd = row_odd;
		next_col_odd = col_odd;
		next_gate_seen = gate_seen;
		next_hold_cnt = hold_cnt;
		next_pix_out = pix_out;
		next_pix_valid = 1'b0;
		stat_set = '0;
		unique case (state)
			ST_IDLE:
				if (ctrl_en & ~en_prev)
				begin
					next_state = ST_CAPTURE;
					next_count = '0;
					next_row_odd = 1'b1;
					next_col_odd = 1'b0;
					next_gate_seen = 1'b0;
				end
			ST_CAPTURE:
				if (pixel_edge && sample_gate)
				begin
					next_pix_valid = 1'b1;
					next_pix_out.data = data_s & width_mask(ctrl_width);
					if (row_odd)
						next_pix_out.colour = col_odd ? COLOUR_RED : COLOUR_GREEN;
					else
						next_pix_out.colour = col_odd ? COLOUR_GREEN : COLOUR_BLUE;
					next_col_odd = ~col_odd;
					next_gate_seen = 1'b1;
					next_count = count_inc;
					// a zero limit wraps to the full 2^24 samples
					if (count_inc == limit_full)
					begin
						next_state = ST_HOLDOFF;
						next_hold_cnt = '0;
						stat_set[STAT_DONE_BIT] = 1'b1;
					end
				end
				else if (pixel_edge && gate_seen)
				begin
					// gate falls between rows, never inside blanking rows
					next_gate_seen = 1'b0;
					next_row_odd = ~row_odd;
					next_col_odd = 1'b0;
				end
			ST_HOLDOFF:
				if (pixel_edge)
				begin
					if (sample_gate)
						stat_set[STAT_GATE_BIT] = 1'b1;
					next_hold_cnt = 2'(hold_cnt + 2'h1);
					if (next_hold_cnt == HOLD_CYCLES)
						next_state = ST_DONE;
				end
			ST_DONE: ;
		endcase
		if (!ctrl_en)
			next_state = ST_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			count <= '0;
			row_odd <= 1'b1;
			col_odd <= 1'b0;
			gate_seen <= 1'b0;
			hold_cnt <= '0;
			pix_out <= '0;
			pix_valid <= 1'b0;
			en_prev <= 1'b0;
			clk_prev <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			row_odd <= next_row_odd;
			col_odd <= next_col_odd;
			gate_seen <= next_gate_seen;
			hold_cnt <= next_hold_cnt;
			pix_out <= next_pix_out;
			pix_valid <= next_pix_valid;
			en_prev <= ctrl_en;
			clk_prev <= clk_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_gate_ignored: assert property (pixel_edge && !sample_gate |=> !pix_valid)
		else $error("word taken while gate inactive");
	chk_raw_data: assert property (state == ST_CAPTURE && ctrl_en
		&& pixel_edge && sample_gate
		|=> pix_valid && pix_out.data == ($past(data_s) & width_mask(ctrl_width)))
		else $error("captured word differs from bus");
	chk_one_per_edge: assert property (pix_valid |-> $past(pixel_edge) && !pixel_edge)
		else $error("sample not tied to pixel clock edge");
	chk_width_upper: assert property (pix_valid
		|-> (pix_out.data & ~width_mask(ctrl_width)) == 20'h00000)
		else $error("bits above word width not zero");
	chk_count_range: assert property (state == ST_CAPTURE
		&& limit_full != 24'h000000 |-> count < limit_full)
		else $error("count beyond limit while capturing");
	chk_stop_limit: assert property (state == ST_CAPTURE && ctrl_en
		&& pixel_edge && sample_gate && count_inc == limit_full
		|=> state == ST_HOLDOFF && status[STAT_DONE_BIT])
		else $error("capture did not stop at limit");
	chk_hold_gate: assert property (state == ST_HOLDOFF && pixel_edge && sample_gate
		|=> status[STAT_GATE_BIT])
		else $error("gate during holdoff not flagged");
	chk_count_clear: assert property (state == ST_IDLE && ctrl_en && !en_prev
		|=> state == ST_CAPTURE && count == 24'h000000)
		else $error("counter not cleared on enable");
	chk_count_step: assert property (state == ST_CAPTURE && ctrl_en
		&& pixel_edge && sample_gate
		|=> count == $past(count_inc) ##1 count == $past(count, 1))
		else $error("counter did not advance by one");
	chk_bayer_odd: assert property (state == ST_CAPTURE && ctrl_en
		&& pixel_edge && sample_gate && row_odd |=> pix_out.colour != COLOUR_BLUE)
		else $error("blue sample on odd row");

	cov_done: cover property (state == ST_HOLDOFF ##[1:300] state == ST_DONE);
	cov_violation: cover property (stat_set[STAT_GATE_BIT]);
	cov_red_pixel: cover property (pix_valid && pix_out.colour == COLOUR_RED);
	cov_irq: cover property ($rose(irq));

endmodule : rpc_capture_port

// ===== verilog/rpc_pkg.sv
package rpc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] LIMIT_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS = 8'h0C;
	localparam logic [7:0] COUNT_OFS = 8'h10;
	localparam logic [7:0] DATA_OFS = 8'h14;

	////////////////////////////////////////////////////////////////////////////////
	// field positions and widths
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_WIDTH_LSB = 1;
	localparam int unsigned LIMIT_FIELD_W = 12;
	localparam int unsigned LIMIT_LOW_LSB = 0;
	localparam int unsigned LIMIT_HIGH_LSB = 16;
	localparam int unsigned COUNT_W = 24;
	localparam int unsigned PORT_W = 20;
	localparam int unsigned STAT_W = 2;
	localparam int unsigned STAT_DONE_BIT = 0;
	localparam int unsigned STAT_GATE_BIT = 1;
	localparam int unsigned COUNT_BUSY_BIT = 31;
	localparam int unsigned DATA_COLOUR_LSB = 24;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and timing
	localparam logic CTRL_EN_RESET = 1'b0;
	localparam logic [11:0] LIMIT_RESET = 12'h000;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam logic [1:0] HOLD_CYCLES = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {WIDTH_8, WIDTH_10, WIDTH_16, WIDTH_20} rpc_width_type;
	typedef enum logic [1:0] {COLOUR_GREEN, COLOUR_RED, COLOUR_BLUE} rpc_colour_type;
	typedef enum logic [1:0] {ST_IDLE, ST_CAPTURE, ST_HOLDOFF, ST_DONE} rpc_state_type;

	typedef struct packed
	{
		logic [19:0] data;
		rpc_colour_type colour;
	} rpc_pixel_type;

	function automatic logic [19:0] width_mask(input rpc_width_type w);
		logic [19:0] m;
		m = 20'h000FF;
		unique case (w)
			WIDTH_8: m = 20'h000FF;
			WIDTH_10: m = 20'h003FF;
			WIDTH_16: m = 20'h0FFFF;
			WIDTH_20: m = 20'hFFFFF;
		endcase
		return m;
	endfunction : width_mask

endpackage : rpc_pkg

// ===== verilog/rpc_sync.sv
`timescale 1ns/1ps
module rpc_sync
	#(parameter int unsigned WIDTH = 1)
	(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
	);

	logic [WIDTH-1:0] stage1;

	// two flops, first stage read only by the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			dout <= '0;
		end
		else
		begin
			stage1 <= din;
			dout <= stage1;
		end
	end

endmodule : rpc_sync
